// >>> shared/sbf_pkg.sv
// Shared constants, size codes and address helpers for the store data bypass.
// Function
// RULE1: Forward matching older store data to load.
// RULE2: Refuse forwarding when start addresses differ.
// RULE3: Refuse when load wider than store.
// RULE4: Refuse when load or store misaligned.
// RULE5: Split byte/word stores in doubleword block forwarding.
// RULE6: Blocked load waits for store, reads cache.
// RULE7: Store commits only after older instructions retire.
// RULE8: Misaligned access costs at least one cycle; here only loads pay it, misaligned stores take no extra cycle.
// RULE9: Alignment mask set enables alignment-check fault; here only loads fault, stores never do.
// RULE10: Aligned means address multiple of size.
// RULE11: Ten-byte object aligned at multiple of eight.
// RULE12: Wide store forwards narrower same-start or upper-quad loads.
// RULE13: Partial match first, full check, cancel and retry.
// RULE14: Youngest matching store is the only source.
// RULE15: Refused load returns fully updated memory data.
package sbf_pkg;

   // Linear address and data path widths.
   localparam int ADDR_W = 48;
   localparam int DATA_W = 128;

   // Low address bits compared in the first match stage (bits 0:11).
   localparam logic [47:0] LO_MASK = 48'h000000000FFF;
   // Lowest address bit compared in the second match stage.
   localparam int HI_LSB = 12;
   // Byte offset of the upper quadword inside a double quadword.
   localparam logic [47:0] UPPER_Q_OFS = 48'h000000000008;
   // Widest load that may take the upper quadword of a double quadword, in bytes.
   localparam logic [4:0] UPPER_Q_MAX = 5'h08;
   // Widest access that counts as a split byte or word store, in bytes.
   localparam logic [4:0] SPLIT_MAX = 5'h02;

   // Operand size codes.
   typedef enum logic [2:0]
   {
      SZ_BYTE = 3'h0,
      SZ_WORD = 3'h1,
      SZ_DWORD = 3'h2,
      SZ_QWORD = 3'h3,
      SZ_TBYTE = 3'h4,
      SZ_DQWORD = 3'h5
   } size_t;

   // Number of bytes an operand of the given size spans.
   function automatic logic [4:0] size_bytes(input size_t s);
      case (s)
         SZ_BYTE: return 5'h01;
         SZ_WORD: return 5'h02;
         SZ_DWORD: return 5'h04;
         SZ_QWORD: return 5'h08;
         SZ_TBYTE: return 5'h0A;
         SZ_DQWORD: return 5'h10;
         default: return 5'h01;
      endcase
   endfunction : size_bytes

   // Natural alignment; the ten-byte object only needs eight-byte alignment.
   function automatic logic is_aligned(input logic [47:0] a, input size_t s);
      case (s)
         SZ_BYTE: return 1'b1;
         SZ_WORD: return a[0] == 1'b0; // see RULE10
         SZ_DWORD: return a[1:0] == 2'h0; // see RULE10
         SZ_QWORD: return a[2:0] == 3'h0; // see RULE10
         SZ_TBYTE: return a[2:0] == 3'h0; // see RULE11
         SZ_DQWORD: return a[3:0] == 4'h0; // see RULE10
         default: return 1'b0;
      endcase
   endfunction : is_aligned

   // True when the two byte ranges share at least one byte.
   function automatic logic overlaps(input logic [47:0] a, input size_t sa,
                                     input logic [47:0] b, input size_t sb);
      logic [48:0] a_end;
      logic [48:0] b_end;
      a_end = {1'b0, a} + {44'h0, size_bytes(sa)};
      b_end = {1'b0, b} + {44'h0, size_bytes(sb)};
      return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
   endfunction : overlaps

endpackage : sbf_pkg

// >>> shared/align_if.sv
// Interface carrying one access to the alignment checker and its verdict.
interface align_if;
   logic [47:0] addr; // Access start address.
   sbf_pkg::size_t size; // Access operand size.
   logic fault_en; // Alignment checking is enabled.
   logic aligned; // Access is naturally aligned.
   logic fault; // Access must raise the alignment-check exception.

   modport chk (input addr, input size, input fault_en, output aligned, output fault);
   modport user (output addr, output size, output fault_en, input aligned, input fault);
endinterface : align_if

// >>> verilog/align_check.sv
// Alignment checker for one memory access.
module align_check
(
   // Access under test.
   align_if.chk acc
);

   // The verdict is purely combinational so the pipeline can act in the same cycle.
   always_comb
   begin
      acc.aligned = sbf_pkg::is_aligned(acc.addr, acc.size); // see RULE10
      // A misaligned access faults only while checking is enabled.
      acc.fault = acc.fault_en && !acc.aligned; // see RULE9
   end

endmodule : align_check

// >>> verilog/store_data_bypass.sv
// Store buffer with store-to-load data bypass, cache commit and load sequencing.
module store_data_bypass #(
   parameter int DEPTH = 8, // Store buffer entries, a power of two.
   parameter int TAG_W = 6 // Reorder buffer tag width.
)
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Control bits.
   input wire logic alignment_mask_i,
   input wire logic align_check_en_i,
   // Store entry from the pipeline.
   input wire logic st_valid_i,
   input wire logic [47:0] st_addr_i,
   input wire sbf_pkg::size_t st_size_i,
   input wire logic [127:0] st_data_i,
   input wire logic [TAG_W-1:0] st_tag_i,
   output logic st_ready_o,
   // Retirement from the reorder buffer.
   input wire logic retire_valid_i,
   input wire logic [TAG_W-1:0] retire_tag_i,
   // Store commit to the data cache.
   output logic dc_wr_valid_o,
   output logic [47:0] dc_wr_addr_o,
   output sbf_pkg::size_t dc_wr_size_o,
   output logic [127:0] dc_wr_data_o,
   input wire logic dc_wr_ready_i,
   // Load request.
   input wire logic ld_valid_i,
   input wire logic [47:0] ld_addr_i,
   input wire sbf_pkg::size_t ld_size_i,
   output logic ld_ready_o,
   // Load result.
   output logic ld_done_o,
   output logic [127:0] ld_data_o,
   output logic ld_fwd_o,
   output logic ld_fault_o,
   output logic ld_cancel_o,
   // Data cache read.
   output logic dc_rd_req_o,
   output logic [47:0] dc_rd_addr_o,
   output sbf_pkg::size_t dc_rd_size_o,
   input wire logic dc_rd_valid_i,
   input wire logic [127:0] dc_rd_data_i
);

   localparam int PTR_W = $clog2(DEPTH);

   // Load sequencer states.
   typedef enum logic [6:0]
   {
      S_IDLE = 7'h01,
      S_PEN = 7'h02,
      S_LOOK = 7'h04,
      S_VER = 7'h08,
      S_WAIT = 7'h10,
      S_RD = 7'h20,
      S_DONE = 7'h40
   } ld_state_t;

   // Store buffer storage, kept in age order from head to tail.
   logic [47:0] st_addr_r [DEPTH]; // Entry start address.
   sbf_pkg::size_t st_sz_r [DEPTH]; // Entry operand size.
   logic [127:0] st_data_r [DEPTH]; // Entry data.
   logic [TAG_W-1:0] st_tag_r [DEPTH]; // Entry reorder buffer tag.
   logic st_aln_r [DEPTH]; // Entry was naturally aligned.
   logic st_ret_r [DEPTH]; // Entry has retired.
   logic [PTR_W-1:0] head_r; // Oldest entry.
   logic [PTR_W-1:0] tail_r; // Next free slot.
   logic [PTR_W:0] cnt_r; // Occupied entries.

   // Load in flight.
   ld_state_t state_r; // Sequencer state.
   ld_state_t state_nxt; // Next sequencer state.
   logic [47:0] ld_addr_r; // Load start address.
   sbf_pkg::size_t ld_sz_r; // Load operand size.
   logic ld_aln_r; // Load is aligned.
   logic retry_r; // Lookup uses the full address after a cancel.
   logic [PTR_W-1:0] cand_r; // Forwarding source chosen in lookup.
   logic up_r; // Source is the upper quadword case.

   // Lookup results.
   logic st_push; // Store accepted this cycle.
   logic st_pop; // Head store written to the cache this cycle.
   logic hit; // Some older store overlaps the load.
   logic [PTR_W-1:0] cand; // Youngest overlapping store.
   logic pair_blk; // Split byte or word stores share the load's doubleword.
   logic same_start; // Source and load start together.
   logic upper_q; // Load starts at the upper quadword of a double quadword store.
   logic fwd_ok; // Forwarding is permitted.
   logic any_ovl; // Some buffered store still overlaps the load, full address.
   logic hi_match; // Second-stage address bits match.

   // Alignment checkers for the incoming load and the incoming store.
   align_if ld_if ();
   align_if st_if ();

   assign ld_if.addr = ld_addr_i;
   assign ld_if.size = ld_size_i;
   assign ld_if.fault_en = alignment_mask_i && align_check_en_i;
   assign st_if.addr = st_addr_i;
   assign st_if.size = st_size_i;
   assign st_if.fault_en = 1'b0;

   align_check u_ld_chk (.acc(ld_if.chk));
   align_check u_st_chk (.acc(st_if.chk));

   // Stores are only taken between loads, so anything buffered during a lookup is older.
   // This costs store throughput while a load waits, but keeps age order exact.
   assign st_ready_o = (cnt_r != (PTR_W+1)'(DEPTH)) && (state_r == S_IDLE);
   assign st_push = st_valid_i && st_ready_o;

   // The head commits only once the reorder buffer has retired it.
   assign dc_wr_valid_o = (cnt_r != '0) && st_ret_r[head_r]; // see RULE7
   assign dc_wr_addr_o = st_addr_r[head_r];
   assign dc_wr_size_o = st_sz_r[head_r];
   assign dc_wr_data_o = st_data_r[head_r];
   assign st_pop = dc_wr_valid_o && dc_wr_ready_i;

   // Pointer and occupancy bookkeeping.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         head_r <= '0;
         tail_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (st_push)
            tail_r <= tail_r + 1'b1;
         if (st_pop)
            head_r <= head_r + 1'b1;
         // Push and pop in one cycle leave the count unchanged.
         if (st_push && !st_pop)
            cnt_r <= cnt_r + 1'b1;
         else if (st_pop && !st_push)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   // Entry contents are written on push; retirement marks are set by tag.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            st_addr_r[i] <= '0;
            st_sz_r[i] <= sbf_pkg::SZ_BYTE;
            st_data_r[i] <= '0;
            st_tag_r[i] <= '0;
            st_aln_r[i] <= 1'b0;
            st_ret_r[i] <= 1'b0;
         end
      end
      else
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            // Retire all instructions older than the store before it may leave.
            if (retire_valid_i && st_tag_r[i] == retire_tag_i)
               st_ret_r[i] <= 1'b1; // see RULE7
         end
         if (st_push)
         begin
            st_addr_r[tail_r] <= st_addr_i;
            st_sz_r[tail_r] <= st_size_i;
            st_data_r[tail_r] <= st_data_i;
            st_tag_r[tail_r] <= st_tag_i;
            st_aln_r[tail_r] <= st_if.aligned;
            st_ret_r[tail_r] <= 1'b0;
         end
      end
   end

   // Address as seen by the lookup: low bits only until a cancel forces a full compare.
   function automatic logic [47:0] look_addr(input logic [47:0] a, input logic full);
      return full ? a : (a & sbf_pkg::LO_MASK); // see RULE13
   endfunction : look_addr

   // Lookup: scan oldest to youngest, the last hit wins.
   always_comb
   begin
      logic [PTR_W-1:0] idx;
      logic [47:0] la;
      logic [47:0] sa;
      idx = '0;
      hit = 1'b0;
      cand = '0;
      pair_blk = 1'b0;
      any_ovl = 1'b0;
      la = look_addr(ld_addr_r, retry_r);
      for (int i = 0; i < DEPTH; i++)
      begin
         idx = head_r + PTR_W'(i);
         if ((PTR_W+1)'(i) < cnt_r)
         begin
            if (sbf_pkg::overlaps(look_addr(st_addr_r[idx], retry_r), st_sz_r[idx],
                                  la, ld_sz_r))
            begin
               hit = 1'b1;
               cand = idx; // see RULE14
            end
            if (sbf_pkg::overlaps(st_addr_r[idx], st_sz_r[idx], ld_addr_r, ld_sz_r))
               any_ovl = 1'b1;
         end
      end
      sa = look_addr(st_addr_r[cand], retry_r);
      // Another byte or word store in the same doubleword with its own start blocks it.
      for (int i = 0; i < DEPTH; i++)
      begin
         idx = head_r + PTR_W'(i);
         if ((PTR_W+1)'(i) < cnt_r && idx != cand &&
             sbf_pkg::size_bytes(ld_sz_r) <= sbf_pkg::SPLIT_MAX &&
             sbf_pkg::size_bytes(st_sz_r[idx]) <= sbf_pkg::SPLIT_MAX &&
             look_addr(st_addr_r[idx], retry_r) != sa &&
             look_addr(st_addr_r[idx], retry_r) >> 2 == la >> 2)
            pair_blk = 1'b1; // see RULE5
      end
      same_start = (sa == la); // see RULE2
      // A double quadword store also feeds small loads at its upper quadword.
      upper_q = (st_sz_r[cand] == sbf_pkg::SZ_DQWORD) && (la == sa + sbf_pkg::UPPER_Q_OFS) &&
                (sbf_pkg::size_bytes(ld_sz_r) <= sbf_pkg::UPPER_Q_MAX); // see RULE12
      fwd_ok = hit && !pair_blk && ld_aln_r && st_aln_r[cand] && // see RULE4
               ((same_start && // see RULE12
                 sbf_pkg::size_bytes(ld_sz_r) <= sbf_pkg::size_bytes(st_sz_r[cand])) || // see RULE3
                upper_q);
   end

   // Second stage compares the page bits of the chosen source.
   assign hi_match = st_addr_r[cand_r][47:sbf_pkg::HI_LSB] == ld_addr_r[47:sbf_pkg::HI_LSB];

   // Sequencer next state.
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (ld_valid_i && ld_if.fault)
               state_nxt = S_DONE; // see RULE9
            else if (ld_valid_i && !ld_if.aligned)
               state_nxt = S_PEN; // see RULE8
            else if (ld_valid_i)
               state_nxt = S_LOOK;
         end
         // Extra cycle paid by every misaligned load that does not fault.
         S_PEN: state_nxt = S_LOOK; // see RULE8
         S_LOOK:
         begin
            if (fwd_ok)
               state_nxt = S_VER; // see RULE1
            else if (hit)
               state_nxt = S_WAIT; // see RULE6
            else
               state_nxt = S_RD;
         end
         // A false partial match is cancelled and looked up again.
         S_VER: state_nxt = hi_match ? S_DONE : S_LOOK; // see RULE13
         // Wait until every overlapping store has reached the cache.
         S_WAIT: state_nxt = any_ovl ? S_WAIT : S_RD; // see RULE6
         S_RD: state_nxt = dc_rd_valid_i ? S_DONE : S_RD;
         S_DONE: state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   // Sequencer state register.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   // Load capture, retry mode and forwarding source.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         ld_addr_r <= '0;
         ld_sz_r <= sbf_pkg::SZ_BYTE;
         ld_aln_r <= 1'b0;
         retry_r <= 1'b0;
         cand_r <= '0;
         up_r <= 1'b0;
      end
      else
      begin
         if (state_r == S_IDLE && ld_valid_i)
         begin
            ld_addr_r <= ld_addr_i;
            ld_sz_r <= ld_size_i;
            ld_aln_r <= ld_if.aligned;
            retry_r <= 1'b0;
         end
         if (state_r == S_LOOK)
         begin
            cand_r <= cand;
            up_r <= upper_q && !same_start;
         end
         if (ld_cancel_o)
            retry_r <= 1'b1; // see RULE13
      end
   end

   // Result data: forwarded data is shifted so the load's first byte is lowest.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         ld_data_o <= '0;
         ld_fwd_o <= 1'b0;
         ld_fault_o <= 1'b0;
      end
      else
      begin
         if (state_r == S_IDLE && ld_valid_i)
         begin
            ld_fault_o <= ld_if.fault; // see RULE9
            ld_fwd_o <= 1'b0;
            ld_data_o <= '0;
         end
         if (state_r == S_VER && hi_match)
         begin
            ld_fwd_o <= 1'b1; // see RULE1
            ld_data_o <= up_r ? {64'h0, st_data_r[cand_r][127:64]} : st_data_r[cand_r];
         end
         if (state_r == S_RD && dc_rd_valid_i)
            ld_data_o <= dc_rd_data_i; // see RULE15
      end
   end

   // Handshake outputs.
   assign ld_ready_o = (state_r == S_IDLE);
   assign ld_done_o = (state_r == S_DONE);
   assign ld_cancel_o = (state_r == S_VER) && !hi_match;
   assign dc_rd_req_o = (state_r == S_RD);
   assign dc_rd_addr_o = ld_addr_r;
   assign dc_rd_size_o = ld_sz_r;

   // Checks on the sequencer and the buffer.
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_take_mis;
      state_r == S_IDLE && ld_valid_i && !ld_if.aligned && !ld_if.fault;
   endsequence

   sequence s_fwd_go;
      state_r == S_LOOK && fwd_ok;
   endsequence

   fwd_latency_a: assert property (s_fwd_go |-> ##1 state_r == S_VER ##1 // see RULE1
                                   ((ld_done_o && ld_fwd_o) || state_r == S_LOOK))
      else $error("Permitted forward did not complete two cycles after lookup.");
   fwd_start_a: assert property (ld_done_o && ld_fwd_o && !up_r |-> // see RULE2
                                 st_addr_r[cand_r] == ld_addr_r)
      else $error("Forward taken from a store with another start address.");
   fwd_width_a: assert property (ld_done_o && ld_fwd_o && !up_r |-> // see RULE3
      sbf_pkg::size_bytes(ld_sz_r) <= sbf_pkg::size_bytes(st_sz_r[cand_r]))
      else $error("Forward taken from a narrower store.");
   fwd_align_a: assert property (ld_done_o && ld_fwd_o |-> ld_aln_r && st_aln_r[cand_r]) // see RULE4
      else $error("Forward taken with a misaligned access.");
   pair_block_a: assert property (state_r == S_LOOK && pair_blk |=> state_r != S_VER) // see RULE5
      else $error("Forward taken despite split stores in the doubleword.");
   wait_clear_a: assert property (dc_rd_req_o |-> !any_ovl) // see RULE6
      else $error("Cache read issued while an overlapping store is buffered.");
   commit_hold_a: assert property (dc_wr_valid_o && !dc_wr_ready_i |=> // see RULE7
                                   dc_wr_valid_o && $stable(dc_wr_addr_o))
      else $error("Cache commit dropped or changed before acceptance.");
   misalign_pen_a: assert property (s_take_mis |=> state_r == S_PEN ##1 state_r == S_LOOK) // see RULE8
      else $error("Misaligned load skipped its penalty cycle.");
   align_fault_a: assert property (state_r == S_IDLE && ld_valid_i && ld_if.fault |=> // see RULE9
                                   ld_done_o && ld_fault_o && !dc_rd_req_o)
      else $error("Alignment fault not reported on the next cycle.");
   upper_quad_a: assert property (ld_done_o && ld_fwd_o && up_r |-> // see RULE12
      st_sz_r[cand_r] == sbf_pkg::SZ_DQWORD && st_addr_r[cand_r] + 48'h8 == ld_addr_r)
      else $error("Upper quadword forward from a wrong source.");
   retry_full_a: assert property (ld_cancel_o |=> state_r == S_LOOK && retry_r) // see RULE13
      else $error("Cancelled load was not retried with a full compare.");

endmodule : store_data_bypass

// >>> tb/cache_model.sv
// Data cache model for commits and load reads.
module cache_model
(
   // Clock and reset.
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Slow mode.
   input wire logic slow_i,
   // Write port.
   input wire logic wr_valid_i,
   input wire logic [47:0] wr_addr_i,
   input wire sbf_pkg::size_t wr_size_i,
   input wire logic [127:0] wr_data_i,
   output logic wr_ready_o,
   // Read port.
   input wire logic rd_req_i,
   input wire logic [47:0] rd_addr_i,
   output logic rd_valid_o,
   output logic [127:0] rd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [0:511]; // Bytes.
   logic [1:0] tick_r; // Slow mode phase.
   logic [127:0] last_r; // Last read data.

   // Byte count of a size.
   function automatic int nb(input sbf_pkg::size_t s);
      case (s)
         sbf_pkg::SZ_WORD: return 2;
         sbf_pkg::SZ_DWORD: return 4;
         sbf_pkg::SZ_QWORD: return 8;
         sbf_pkg::SZ_TBYTE: return 10;
         sbf_pkg::SZ_DQWORD: return 16;
         default: return 1;
      endcase
   endfunction : nb

   // Slow mode: writes every other cycle, late reads.
   assign wr_ready_o = !slow_i || tick_r[0];
   assign rd_valid_o = rd_req_i && (!slow_i || tick_r == 2'h3);

   // Idle cycles show inverted old data.
   always_comb
   begin
      for (int i = 0; i < 16; i++)
         rd_data_o[8*i +: 8] = mem_r[9'(rd_addr_i + 48'(i))];
      if (!rd_valid_o)
         rd_data_o = ~last_r;
   end

   // Writes, pacing and read history; the phase is reset so slow mode never sees unknowns.
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         tick_r <= 2'h0;
         last_r <= '0;
         for (int i = 0; i < 512; i++)
            mem_r[i] <= 8'(i) ^ 8'h5A;
      end
      else
      begin
         tick_r <= tick_r + 2'h1;
         if (rd_valid_o)
            last_r <= rd_data_o;
         if (wr_valid_i && wr_ready_o)
            for (int i = 0; i < nb(wr_size_i); i++)
               mem_r[9'(wr_addr_i + 48'(i))] <= wr_data_i[8*i +: 8];
      end
   end
endmodule : cache_model

// >>> tb/tb_top.sv
// Testbench of the store data bypass.
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, reset_n_i = 1'b0, st_valid_i = 1'b0;
   logic alignment_mask_i = 1'b0, align_check_en_i = 1'b0;
   logic [47:0] st_addr_i = 48'h0;
   sbf_pkg::size_t st_size_i = sbf_pkg::SZ_BYTE;
   logic [127:0] st_data_i = 128'h0;
   logic [5:0] st_tag_i = 6'h0;
   logic [5:0] retire_tag_i;
   logic retire_valid_i = 1'b0, ld_valid_i = 1'b0;
   logic [47:0] ld_addr_i = 48'h0;
   sbf_pkg::size_t ld_size_i = sbf_pkg::SZ_BYTE;
   logic slow = 1'b0;
   logic st_ready_o, dc_wr_valid_o, dc_wr_ready_i, ld_ready_o, ld_done_o;
   logic ld_fwd_o, ld_fault_o, ld_cancel_o, dc_rd_req_o, dc_rd_valid_i;
   logic [47:0] dc_wr_addr_o, dc_rd_addr_o;
   sbf_pkg::size_t dc_wr_size_o, dc_rd_size_o;
   logic [127:0] dc_wr_data_o, ld_data_o, dc_rd_data_i;
   logic [7:0] sh [0:511]; // Expected memory.
   int fails = 0, cmp_count = 0;
   int lat; // Load latency.
   logic cx; // Cancel seen.

   // Retirement always names the tag of the stores being pushed.
   assign retire_tag_i = st_tag_i;

   store_data_bypass #(.DEPTH(8), .TAG_W(6)) i_store_data_bypass (.*);
   cache_model i_cache_model (.clk_sys_i, .reset_n_i, .slow_i(slow),
      .wr_valid_i(dc_wr_valid_o), .wr_addr_i(dc_wr_addr_o), .wr_size_i(dc_wr_size_o),
      .wr_data_i(dc_wr_data_o), .wr_ready_o(dc_wr_ready_i), .rd_req_i(dc_rd_req_o),
      .rd_addr_i(dc_rd_addr_o), .rd_valid_o(dc_rd_valid_i), .rd_data_o(dc_rd_data_i));

   always #12.5 clk_sys_i = ~clk_sys_i;

   // Verdict.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   // One store, held until ready is seen before the taking edge.
   task automatic st(input logic [47:0] a, input sbf_pkg::size_t s, input logic [127:0] d);
      int k = 0;
      st_addr_i = a;
      st_size_i = s;
      st_data_i = d;
      st_valid_i = 1'b1;
      while (st_ready_o !== 1'b1 && k < 50)
      begin
         k++;
         @(negedge clk_sys_i);
      end
      @(negedge clk_sys_i);
      for (int i = 0; i < i_cache_model.nb(s); i++)
         sh[9'(a + 48'(i))] = d[8*i +: 8];
   endtask : st

   // One load; retire pulse at cycle rdel.
   task automatic ld(input logic [47:0] a, input sbf_pkg::size_t s, input int rdel);
      st_valid_i = 1'b0;
      @(negedge clk_sys_i);
      ld_addr_i = a;
      ld_size_i = s;
      ld_valid_i = 1'b1;
      lat = 0;
      cx = 1'b0;
      @(negedge clk_sys_i);
      ld_valid_i = 1'b0;
      while (lat < 60)
      begin
         lat++;
         cx |= (ld_cancel_o === 1'b1);
         if (ld_done_o === 1'b1)
            break;
         retire_valid_i = (lat == rdel);
         @(negedge clk_sys_i);
      end
      retire_valid_i = 1'b0;
      `CHK("load finished", 1'b1, ld_done_o)
   endtask : ld

   // Loaded bytes against expected memory.
   task automatic dchk(input logic [47:0] a, input sbf_pkg::size_t s);
      logic [127:0] e;
      logic [127:0] m;
      e = 128'h0;
      m = 128'h0;
      for (int i = 0; i < i_cache_model.nb(s); i++)
      begin
         e[8*i +: 8] = sh[9'(a + 48'(i))];
         m[8*i +: 8] = 8'hFF;
      end
      `CHK("load data", e, ld_data_o & m)
   endtask : dchk

   // Retire the tag and drain.
   task automatic ret();
      int k = 0;
      st_valid_i = 1'b0;
      `CHK("commit before retire", 1'b0, dc_wr_valid_o)
      retire_valid_i = 1'b1;
      @(negedge clk_sys_i);
      retire_valid_i = 1'b0;
      @(negedge clk_sys_i);
      while (dc_wr_valid_o === 1'b1 && k < 40)
      begin
         k++;
         @(negedge clk_sys_i);
      end
      `CHK("buffer drained", 1'b0, dc_wr_valid_o)
   endtask : ret

   // Younger of two stores feeds same-size and narrow loads.
   task automatic t_fwd();
      st_tag_i = 6'h01;
      st(48'h040, sbf_pkg::SZ_DWORD, 128'h11223344);
      st(48'h040, sbf_pkg::SZ_DWORD, 128'hA1B2C3D4);
      ld(48'h040, sbf_pkg::SZ_DWORD, 0);
      `CHK("fwd lat", 3, lat)
      `CHK("fwd flag", 1'b1, ld_fwd_o)
      dchk(48'h040, sbf_pkg::SZ_DWORD);
      ld(48'h040, sbf_pkg::SZ_BYTE, 0);
      `CHK("narrow fwd", 1'b1, ld_fwd_o)
      dchk(48'h040, sbf_pkg::SZ_BYTE);
      st_tag_i = 6'h02;
      st(48'h080, sbf_pkg::SZ_DQWORD, 128'hFEDCBA98_76543210_0F1E2D3C_4B5A6978);
      ld(48'h088, sbf_pkg::SZ_QWORD, 0);
      `CHK("upper fwd", 1'b1, ld_fwd_o)
      dchk(48'h088, sbf_pkg::SZ_QWORD);
      st_tag_i = 6'h01;
      ret();
      st_tag_i = 6'h02;
      ret();
   endtask : t_fwd

   // Refused loads wait, then read the cache.
   task automatic t_block();
      logic [47:0] sa [4] = '{48'h100, 48'h110, 48'h124, 48'h130};
      sbf_pkg::size_t ss [4] = '{sbf_pkg::SZ_DWORD, sbf_pkg::SZ_BYTE, sbf_pkg::SZ_QWORD,
                                  sbf_pkg::SZ_BYTE};
      logic [47:0] la [4] = '{48'h102, 48'h110, 48'h124, 48'h130};
      sbf_pkg::size_t ls [4] = '{sbf_pkg::SZ_WORD, sbf_pkg::SZ_DWORD, sbf_pkg::SZ_QWORD,
                                  sbf_pkg::SZ_BYTE};
      for (int i = 0; i < 4; i++)
      begin
         st_tag_i = 6'(8 + i);
         slow = (i == 2);
         st(sa[i], ss[i], 128'hC0DE_5EED_9876_1234 + 128'(i));
         if (i == 3)
            st(48'h131, sbf_pkg::SZ_BYTE, 128'h77);
         ld(la[i], ls[i], 6);
         `CHK("refused", 1'b0, ld_fwd_o)
         `CHK("held past retire", 1'b1, lat > 6)
         dchk(la[i], ls[i]);
      end
      slow = 1'b0;
   endtask : t_block

   // Misaligned load costs one cycle more.
   task automatic t_pen();
      int base;
      ld(48'h150, sbf_pkg::SZ_QWORD, 0);
      base = lat;
      dchk(48'h150, sbf_pkg::SZ_QWORD);
      ld(48'h154, sbf_pkg::SZ_QWORD, 0);
      `CHK("penalty", base + 1, lat)
      dchk(48'h154, sbf_pkg::SZ_QWORD);
   endtask : t_pen

   // Alignment faults, then either enable low.
   task automatic t_fault();
      logic [47:0] fa [9] = '{48'h161, 48'h162, 48'h168, 48'h164, 48'h164, 48'h16A,
                              48'h170, 48'h178, 48'h163};
      sbf_pkg::size_t fs [9] = '{sbf_pkg::SZ_WORD, sbf_pkg::SZ_WORD, sbf_pkg::SZ_TBYTE,
                                 sbf_pkg::SZ_TBYTE, sbf_pkg::SZ_DWORD, sbf_pkg::SZ_DWORD,
                                 sbf_pkg::SZ_DQWORD, sbf_pkg::SZ_DQWORD, sbf_pkg::SZ_BYTE};
      logic fe [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      alignment_mask_i = 1'b1;
      align_check_en_i = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         ld(fa[i], fs[i], 0);
         `CHK("fault", fe[i], ld_fault_o)
         if (fe[i])
            `CHK("fault lat", 1, lat)
      end
      alignment_mask_i = 1'b0;
      ld(48'h161, sbf_pkg::SZ_WORD, 0);
      `CHK("mask off", 1'b0, ld_fault_o)
      alignment_mask_i = 1'b1;
      align_check_en_i = 1'b0;
      ld(48'h161, sbf_pkg::SZ_WORD, 0);
      `CHK("check off", 1'b0, ld_fault_o)
   endtask : t_fault

   // Same low bits, other page: cancel and retry.
   task automatic t_cancel();
      st_tag_i = 6'h20;
      st(48'h1180, sbf_pkg::SZ_DWORD, 128'h5555AAAA);
      ld(48'h2180, sbf_pkg::SZ_DWORD, 0);
      `CHK("cancel seen", 1'b1, cx)
      `CHK("no false fwd", 1'b0, ld_fwd_o)
      ret();
   endtask : t_cancel

   // Six cycles of reset, then the scenarios.
   initial
   begin
      for (int i = 0; i < 512; i++)
         sh[i] = 8'(i) ^ 8'h5A;
      repeat (6) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      `CHK("st ready", 1'b1, st_ready_o)
      `CHK("ld ready", 1'b1, ld_ready_o)
      `CHK("wr idle", 1'b0, dc_wr_valid_o)
      `CHK("rd idle", 1'b0, dc_rd_req_o)
      t_fwd();
      t_block();
      t_pen();
      t_fault();
      t_cancel();
      test_done();
   end

   // Watchdog at 20000 cycles, far beyond the few hundred cycles needed.
   initial
   begin
      #(25 * 20000);
      fails++;
      test_done();
   end
endmodule : tb_top
